// >>> common/tsc_pkg.sv
// constants for the two-wire bus status and control block
// assumes a 32-bit apb slave at 50 MHz with open-drain scl and sda pins
package tsc_pkg;
	localparam logic [4:0] OFS_CON = 5'h00;
	localparam logic [4:0] OFS_STAT = 5'h04;
	localparam logic [4:0] OFS_MSK = 5'h08;
	localparam logic [4:0] OFS_TRN = 5'h0C;
	localparam logic [4:0] OFS_RCV = 5'h10;
	localparam logic [4:0] OFS_ADD = 5'h14;
	localparam logic [4:0] OFS_BRG = 5'h18;
	// control fields
	localparam int CON_EN = 15;
	localparam int CON_A10M = 10;
	localparam int CON_GCEN = 7;
	localparam int CON_ACK_VALUE = 5;
	localparam int CON_ACK_SEQ_TRIGGER = 4;
	localparam int CON_MASTER_RX_ENABLE = 3;
	localparam int CON_PEN = 2;
	localparam int CON_RESTART_TRIGGER = 1;
	localparam int CON_SEN = 0;
	localparam logic [15:0] CON_WMASK = 16'h84FF;
	// status fields
	localparam int ST_ACK_STATUS_FLAG = 15;
	localparam int ST_TX_IN_PROGRESS_FLAG = 14;
	localparam int ST_BCL = 10;
	localparam int ST_GC = 9;
	localparam int ST_TEN_BIT_MATCH_FLAG = 8;
	localparam int ST_WRITE_COLLISION_FLAG = 7;
	localparam int ST_OV = 6;
	localparam int ST_DA = 5;
	localparam int ST_P = 4;
	localparam int ST_S = 3;
	localparam int ST_RW = 2;
	localparam int ST_RBF = 1;
	localparam int ST_TBF = 0;
	localparam logic [15:0] CON_RST = 16'h0000;
	localparam logic [9:0] MSK_RST = 10'h000;
	localparam logic [9:0] ADD_RST = 10'h000;
	localparam logic [15:0] BRG_RST = 16'h0004;
	localparam logic [4:0] TEN_BIT_HDR = 5'h1E;
	localparam logic [7:0] GEN_CALL = 8'h00;
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] ACK_SLOT_BIT = 4'h8;
	typedef enum logic [2:0] {M_IDLE, M_START, M_RESTART, M_STOP, M_TX, M_RX, M_ACK} tsc_mst_t;
	typedef enum logic [1:0] {S_OFF, S_ADDR1, S_ADDR2, S_DATA} tsc_slv_t;
endpackage

// >>> rtl/tsc_ctrl.sv
// two-wire bus controller: master sequencer, slave receive, status and mask
// assumes apb master, pins taken as synchronous to pclk, external pull-ups
`timescale 1ns/1ps
`default_nettype none
module tsc_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [4:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic rx_byte_pulse
);
	import tsc_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	logic [15:0] con_r, brg_r, brg_cnt_r;
	logic [9:0] msk_r, add_r;
	logic [7:0] trn_r, rcv_r, m_sh_r, s_sh_r;
	logic [31:0] prdata_r;
	logic ack_status_flag_r, tx_in_progress_flag_r, bcl_r, gc_r, ten_bit_match_flag_r, write_collision_flag_r, ov_r;
	logic da_r, p_r, s_r, rw_r, rbf_r, tbf_r, m_act_r, rx_pulse_r;
	logic m_scl_low_r, m_sda_low_r, s_sda_low_r, scl_q_r, sda_q_r, s_ack_r;
	logic [1:0] m_ph_r;
	logic [3:0] m_bit_r, s_cnt_r;
	tsc_mst_t m_st_r;
	tsc_slv_t s_st_r;
	logic wr_acc, rd_acc, setup, unmapped, start_det, stop_det, tick, stall;
	logic m_coll, m_done, tx_done, rx_done, tx_go, trn_wr, trn_busy, rcv_rd;
	logic scl_rise, scl_fall, s_byte_end, s_hit7, s_hit_hdr, s_hit_lo, s_gc;
	logic s_addr_hit, s_data_done, rx_load, m_sda_bit;
	logic [7:0] s_byte, rx_byte;
	logic [15:0] stat;

	////////////////////////////////////////////////////////////////////////////
	// apb: zero wait states, so reads are prepared in the setup cycle
	assign setup = psel & ~penable;
	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	assign unmapped = (paddr > OFS_BRG) | (paddr[1:0] != 2'b00);
	assign pready = 1'b1;
	assign pslverr = psel & penable & unmapped;
	assign prdata = prdata_r;
	assign trn_wr = wr_acc & (paddr == OFS_TRN);
	assign rcv_rd = rd_acc & (paddr == OFS_RCV);
	assign trn_busy = (m_st_r != M_IDLE) | tbf_r;

	assign stat = {ack_status_flag_r, tx_in_progress_flag_r, 3'b000, bcl_r, gc_r, ten_bit_match_flag_r,
		write_collision_flag_r, ov_r, da_r, p_r, s_r, rw_r, rbf_r, tbf_r};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (setup) begin
			if (paddr == OFS_CON) begin
				prdata_r <= {16'h0000, con_r};
			end else if (paddr == OFS_STAT) begin
				prdata_r <= {16'h0000, stat};
			end else if (paddr == OFS_MSK) begin
				prdata_r <= {22'h000000, msk_r};
			end else if (paddr == OFS_TRN) begin
				prdata_r <= {24'h000000, trn_r};
			end else if (paddr == OFS_RCV) begin
				prdata_r <= {24'h000000, rcv_r};
			end else if (paddr == OFS_ADD) begin
				prdata_r <= {22'h000000, add_r};
			end else if (paddr == OFS_BRG) begin
				prdata_r <= {16'h0000, brg_r};
			end else begin
				prdata_r <= 32'h0000_0000;
			end
		end
	end

	// software write of a trigger wins over a hardware clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			con_r <= CON_RST;
		end else begin
			if (m_done | m_coll) begin
				con_r[CON_ACK_SEQ_TRIGGER:CON_SEN] <= 5'b00000;
			end
			if (wr_acc & (paddr == OFS_CON)) begin
				con_r <= pwdata[15:0] & CON_WMASK;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			msk_r <= MSK_RST;
			add_r <= ADD_RST;
			brg_r <= BRG_RST;
		end else if (wr_acc) begin
			if (paddr == OFS_MSK) begin
				msk_r <= pwdata[9:0];
			end else if (paddr == OFS_ADD) begin
				add_r <= pwdata[9:0];
			end else if (paddr == OFS_BRG) begin
				brg_r <= pwdata[15:0];
			end
		end
	end

	// a transmit write while busy is dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trn_r <= 8'h00;
		end else if (trn_wr & ~trn_busy) begin
			trn_r <= pwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bus condition detection from the previous pin sample
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_q_r <= scl_in;
			sda_q_r <= sda_in;
		end
	end
	assign start_det = scl_in & scl_q_r & sda_q_r & ~sda_in;
	assign stop_det = scl_in & scl_q_r & ~sda_q_r & sda_in;
	assign scl_rise = scl_in & ~scl_q_r;
	assign scl_fall = ~scl_in & scl_q_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p_r <= 1'b0;
			s_r <= 1'b0;
		end else if (start_det) begin
			p_r <= 1'b0;
			s_r <= 1'b1;
		end else if (stop_det) begin
			p_r <= 1'b1;
			s_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// master sequencer: four quarter phases of brg+1 cycles each
	// phase 2 waits for scl high so a stretching slave holds us back
	assign stall = (m_ph_r == 2'd2) & ~scl_in &
		((m_st_r == M_TX) | (m_st_r == M_RX) | (m_st_r == M_ACK));
	assign tick = (brg_cnt_r >= brg_r) & ~stall;
	assign tx_go = tbf_r & m_act_r & ~tx_in_progress_flag_r & (con_r[CON_ACK_SEQ_TRIGGER:CON_SEN] == 5'b00000);
	assign m_sda_bit = (m_st_r == M_TX) ? ((m_bit_r < ACK_SLOT_BIT) & ~m_sh_r[7]) :
		(m_st_r == M_ACK) ? ~con_r[CON_ACK_VALUE] : 1'b0;
	// a released sda read low at the sampling point means another master won
	assign m_coll = tick & (m_ph_r == 2'd2) & ~m_sda_low_r & ~sda_in &
		(((m_st_r == M_TX) & (m_bit_r < ACK_SLOT_BIT)) | (m_st_r == M_ACK));
	assign tx_done = tick & (m_st_r == M_TX) & (m_ph_r == 2'd3) & (m_bit_r == ACK_SLOT_BIT);
	assign rx_done = tick & (m_st_r == M_RX) & (m_ph_r == 2'd3) & (m_bit_r == LAST_DATA_BIT);
	always_comb begin
		m_done = 1'b0;
		if (tick) begin
			case (m_st_r)
				M_START: m_done = (m_ph_r == 2'd2);
				M_RESTART: m_done = (m_ph_r == 2'd3);
				M_STOP: m_done = (m_ph_r == 2'd2);
				M_RX: m_done = rx_done;
				M_ACK: m_done = (m_ph_r == 2'd3);
				default: m_done = 1'b0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			brg_cnt_r <= 16'h0000;
		end else if ((m_st_r == M_IDLE) | tick) begin
			brg_cnt_r <= 16'h0000;
		end else if (~stall) begin
			brg_cnt_r <= brg_cnt_r + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			m_st_r <= M_IDLE;
			m_ph_r <= 2'd0;
			m_bit_r <= 4'h0;
			m_sh_r <= 8'h00;
			m_scl_low_r <= 1'b0;
			m_sda_low_r <= 1'b0;
		end else if (m_st_r == M_IDLE) begin
			m_ph_r <= 2'd0;
			m_bit_r <= 4'h0;
			if (con_r[CON_EN] & ~bcl_r) begin
				if (con_r[CON_SEN]) begin
					m_st_r <= M_START;
				end else if (con_r[CON_RESTART_TRIGGER]) begin
					m_st_r <= M_RESTART;
				end else if (con_r[CON_PEN]) begin
					m_st_r <= M_STOP;
				end else if (con_r[CON_MASTER_RX_ENABLE]) begin
					m_st_r <= M_RX;
				end else if (con_r[CON_ACK_SEQ_TRIGGER]) begin
					m_st_r <= M_ACK;
				end else if (tx_go) begin
					m_st_r <= M_TX;
					m_sh_r <= trn_r;
				end
			end
		end else if (m_coll) begin
			m_st_r <= M_IDLE;
			m_scl_low_r <= 1'b0;
			m_sda_low_r <= 1'b0;
		end else if (tick) begin
			m_ph_r <= m_ph_r + 2'd1;
			case (m_st_r)
				M_START: begin
					if (m_ph_r == 2'd0) m_sda_low_r <= 1'b1;
					if (m_ph_r == 2'd1) m_scl_low_r <= 1'b1;
					if (m_ph_r == 2'd2) m_st_r <= M_IDLE;
				end
				M_RESTART: begin
					if (m_ph_r == 2'd0) m_sda_low_r <= 1'b0;
					if (m_ph_r == 2'd1) m_scl_low_r <= 1'b0;
					if (m_ph_r == 2'd2) m_sda_low_r <= 1'b1;
					if (m_ph_r == 2'd3) begin
						m_scl_low_r <= 1'b1;
						m_st_r <= M_IDLE;
					end
				end
				M_STOP: begin
					if (m_ph_r == 2'd0) m_sda_low_r <= 1'b1;
					if (m_ph_r == 2'd1) m_scl_low_r <= 1'b0;
					if (m_ph_r == 2'd2) begin
						m_sda_low_r <= 1'b0;
						m_st_r <= M_IDLE;
					end
				end
				default: begin
					if (m_ph_r == 2'd0) begin
						m_scl_low_r <= 1'b1;
						m_sda_low_r <= m_sda_bit;
					end
					if (m_ph_r == 2'd1) m_scl_low_r <= 1'b0;
					if (m_ph_r == 2'd2) m_sh_r <= {m_sh_r[6:0], sda_in};
					if (m_ph_r == 2'd3) begin
						m_scl_low_r <= 1'b1;
						m_bit_r <= m_bit_r + 4'h1;
						if (tx_done | rx_done | (m_st_r == M_ACK)) begin
							m_st_r <= M_IDLE;
							m_sda_low_r <= 1'b0;
						end
					end
				end
			endcase
		end
	end

	// the master owns the bus from its own start until any stop is seen or it loses arbitration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			m_act_r <= 1'b0;
		end else if (m_done & (m_st_r == M_START)) begin
			m_act_r <= 1'b1;
		end else if (stop_det | m_coll) begin
			m_act_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// slave receive path; slave transmit data is not produced by this block
	assign s_byte = {s_sh_r[6:0], sda_in};
	assign s_byte_end = scl_rise & (s_cnt_r == LAST_DATA_BIT) & (s_st_r != S_OFF);
	assign s_hit7 = (((s_byte[7:1] ^ add_r[6:0]) & ~msk_r[6:0]) == 7'h00);
	assign s_hit_hdr = (s_byte[7:3] == TEN_BIT_HDR) &
		(((s_byte[2:1] ^ add_r[9:8]) & ~msk_r[9:8]) == 2'b00);
	assign s_hit_lo = (((s_byte ^ add_r[7:0]) & ~msk_r[7:0]) == 8'h00);
	assign s_gc = con_r[CON_GCEN] & (s_byte == GEN_CALL) & (s_st_r == S_ADDR1);
	always_comb begin
		s_addr_hit = 1'b0;
		if (s_byte_end & ~m_act_r) begin
			if (s_st_r == S_ADDR1) begin
				s_addr_hit = s_gc | (con_r[CON_A10M] ? (s_hit_hdr & (~s_byte[0] | ten_bit_match_flag_r)) : s_hit7);
			end else if (s_st_r == S_ADDR2) begin
				s_addr_hit = s_hit_lo;
			end
		end
	end
	assign s_data_done = s_byte_end & ~m_act_r & (s_st_r == S_DATA);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_st_r <= S_OFF;
			s_cnt_r <= 4'h0;
			s_sh_r <= 8'h00;
			s_sda_low_r <= 1'b0;
			s_ack_r <= 1'b0;
		end else if (~con_r[CON_EN] | stop_det | m_act_r) begin
			s_st_r <= S_OFF;
			s_cnt_r <= 4'h0;
			s_sda_low_r <= 1'b0;
		end else if (start_det) begin
			s_st_r <= S_ADDR1;
			s_cnt_r <= 4'h0;
			s_sda_low_r <= 1'b0;
		end else if (scl_rise & (s_cnt_r < ACK_SLOT_BIT) & (s_st_r != S_OFF)) begin
			s_sh_r <= s_byte;
			// decided at the eighth bit: a missed address or a full buffer is not acknowledged
			s_ack_r <= s_addr_hit | (s_data_done & ~rbf_r);
			s_cnt_r <= s_cnt_r + 4'h1;
			if (s_byte_end & ~(s_addr_hit | (s_data_done & ~rbf_r))) begin
				s_st_r <= S_OFF;
			end else if (s_addr_hit) begin
				if ((s_st_r == S_ADDR1) & con_r[CON_A10M] & ~s_gc & ~s_byte[0]) begin
					s_st_r <= S_ADDR2;
				end else if (s_byte[0] & (s_st_r == S_ADDR1)) begin
					s_st_r <= S_OFF;
				end else begin
					s_st_r <= S_DATA;
				end
			end
		end else if (scl_fall & (s_cnt_r == ACK_SLOT_BIT)) begin
			s_sda_low_r <= s_ack_r;
			s_cnt_r <= s_cnt_r + 4'h1;
		end else if (scl_fall & (s_cnt_r > ACK_SLOT_BIT)) begin
			s_sda_low_r <= 1'b0;
			s_cnt_r <= 4'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// receive buffer; on overflow the unread byte is kept
	assign rx_load = rx_done | s_data_done;
	// the master shift register already holds all eight bits at its last phase
	assign rx_byte = rx_done ? m_sh_r : s_byte;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rcv_r <= 8'h00;
			rx_pulse_r <= 1'b0;
		end else begin
			rx_pulse_r <= rx_load & ~rbf_r;
			if (rx_load & ~rbf_r) begin
				rcv_r <= rx_byte;
			end
		end
	end

	// set wins over clear for every hardware-set flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rbf_r <= 1'b0;
			tbf_r <= 1'b0;
		end else begin
			if (rx_load) begin
				rbf_r <= 1'b1;
			end else if (rcv_rd) begin
				rbf_r <= 1'b0;
			end
			if (trn_wr & ~trn_busy) begin
				tbf_r <= 1'b1;
			end else if (tx_done | (m_coll & (m_st_r == M_TX))) begin
				tbf_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_status_flag_r <= 1'b0;
			tx_in_progress_flag_r <= 1'b0;
		end else begin
			if (tx_done) begin
				ack_status_flag_r <= m_sh_r[0];
			end
			if ((m_st_r == M_IDLE) & con_r[CON_EN] & ~bcl_r & tx_go &
				(con_r[CON_ACK_SEQ_TRIGGER:CON_SEN] == 5'b00000)) begin
				tx_in_progress_flag_r <= 1'b1;
			end else if (tx_done | m_coll) begin
				tx_in_progress_flag_r <= 1'b0;
			end
		end
	end

	// software clears the sticky error flags by writing 0 to them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bcl_r <= 1'b0;
			write_collision_flag_r <= 1'b0;
			ov_r <= 1'b0;
		end else begin
			if (m_coll) begin
				bcl_r <= 1'b1;
			end else if (wr_acc & (paddr == OFS_STAT) & ~pwdata[ST_BCL]) begin
				bcl_r <= 1'b0;
			end
			if (trn_wr & trn_busy) begin
				write_collision_flag_r <= 1'b1;
			end else if (wr_acc & (paddr == OFS_STAT) & ~pwdata[ST_WRITE_COLLISION_FLAG]) begin
				write_collision_flag_r <= 1'b0;
			end
			if (rx_load & rbf_r) begin
				ov_r <= 1'b1;
			end else if (wr_acc & (paddr == OFS_STAT) & ~pwdata[ST_OV]) begin
				ov_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gc_r <= 1'b0;
			ten_bit_match_flag_r <= 1'b0;
			da_r <= 1'b0;
			rw_r <= 1'b0;
		end else begin
			if (s_addr_hit & s_gc) begin
				gc_r <= 1'b1;
			end else if (stop_det) begin
				gc_r <= 1'b0;
			end
			if (s_addr_hit & (s_st_r == S_ADDR2)) begin
				ten_bit_match_flag_r <= 1'b1;
			end else if (stop_det) begin
				ten_bit_match_flag_r <= 1'b0;
			end
			if (s_data_done) begin
				da_r <= 1'b1;
			end else if (s_addr_hit) begin
				da_r <= 1'b0;
			end
			if (s_addr_hit & (s_st_r == S_ADDR1)) begin
				rw_r <= s_byte[0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// open-drain pins: only ever pull low
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = m_scl_low_r;
	assign sda_oe = m_sda_low_r | s_sda_low_r;
	assign rx_byte_pulse = rx_pulse_r;
endmodule // tsc_ctrl
`default_nettype wire

// >>> tb/tsc_chk.sv
// port assertions for the two-wire bus controller
// assumes it is bound onto tsc_ctrl with the baud reload left at reset
`timescale 1ns/1ps
`default_nettype none
module tsc_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [4:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic rx_byte_pulse
);
	import tsc_pkg::*;
	logic acc;
	logic bad;
	assign acc = psel && penable;
	assign bad = paddr[1:0] != 2'h0 || paddr > OFS_BRG;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////
	unmapped_err_a: assert property (acc && bad |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (acc && !bad |-> !pslverr)
		else $error("mapped access refused");
	ready_now_a: assert property (psel |-> pready)
		else $error("wait state inserted");
	mask_width_a: assert property (acc && !pwrite && paddr == OFS_MSK |-> prdata[31:10] == 22'h0)
		else $error("mask reads beyond ten bits");
	con_holes_a: assert property (acc && !pwrite && paddr == OFS_CON |->
		prdata[31:16] == 16'h0 && prdata[14:11] == 4'h0 && prdata[9:8] == 2'h0)
		else $error("control hole bits set");
	stat_holes_a: assert property (acc && !pwrite && paddr == OFS_STAT |->
		prdata[31:16] == 16'h0 && prdata[13:11] == 3'h0)
		else $error("status hole bits set");
	pulse_once_a: assert property (rx_byte_pulse |=> !rx_byte_pulse)
		else $error("receive pulse too long");
	start_then_clk_a: assert property ($rose(sda_oe) && scl_in |-> ##[1:100] scl_oe)
		else $error("start not followed by clock low");
	stop_idle_a: assert property ($fell(sda_oe) && scl_in |=> !scl_oe [*8])
		else $error("clock pulled after stop");
	clk_low_a: assert property ($rose(scl_oe) |-> scl_oe [*4])
		else $error("clock low phase too short");
	pins_low_a: assert property (!scl_out && !sda_out)
		else $error("pin drive level not low");
	cover property (rx_byte_pulse);
	cover property (acc && pslverr);
	cover property ($rose(sda_oe) && scl_in);
endmodule // tsc_chk
`default_nettype wire

// >>> tb/tsc_bus_model.sv
// behavioural far-side device on the two-wire bus
// assumes wired-and levels with pull-ups; never stretches the clock
`timescale 1ns/1ps
`default_nettype none
module tsc_bus_model (
	input wire logic scl,
	input wire logic sda,
	input wire logic send_mode,
	input wire logic [7:0] send_byte,
	input wire logic nack_sel,
	input wire logic grab_sda,
	output logic sda_pull,
	output logic [7:0] got_byte,
	output logic got_ack
);
	int cnt;
	logic [7:0] shift;
	logic drv;
	initial begin
		cnt = 0;
		shift = 8'h00;
		drv = 1'b0;
		got_byte = 8'h00;
		got_ack = 1'b0;
	end
	// a falling data line with the clock high frames a new transfer
	always @(negedge sda) if (scl) cnt = 0;
	// msb first, ninth bit is the acknowledge
	always @(posedge scl) begin
		if (cnt < 8) shift = {shift[6:0], sda};
		else begin
			got_byte = shift;
			got_ack = sda;
		end
		cnt = (cnt == 8) ? 0 : cnt + 1;
	end
	// data changes only while the clock is low; released lines float high
	always @(negedge scl or posedge send_mode)
		drv = send_mode ? (cnt < 8 && !send_byte[7 - cnt]) : (cnt == 8 && !nack_sel);
	assign sda_pull = grab_sda || drv;
endmodule // tsc_bus_model
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for tsc_ctrl over apb with a far-side bus model
// assumes tsc_chk and tsc_bus_model compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
	import tsc_pkg::*;
	typedef struct {logic wr; logic [4:0] a; logic [31:0] d; logic [31:0] exp;} tsc_row_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_byte_pulse;
	logic scl_out, scl_oe, sda_out, sda_oe, send_mode, nack_sel, grab_sda, sda_pull, got_ack;
	logic err_seen, ack_bit, tb_scl_low, tb_sda_low;
	logic [4:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0] send_byte, got_byte;
	wire scl;
	wire sda;
	int num_errors, checks, pulses;
	tsc_row_t rows [8] = '{
		'{0, OFS_CON, 0, 0}, '{0, OFS_STAT, 0, 0}, '{0, OFS_MSK, 0, 0},
		'{1, OFS_MSK, 32'hFFFF, 32'h3FF}, '{1, OFS_MSK, 32'h1, 32'h1},
		'{1, OFS_ADD, 32'h51, 32'h51}, '{1, OFS_STAT, 32'hFFFF, 0}, '{1, 5'h1C, 32'hFFFF, 0}};
	assign scl = !(scl_oe || tb_scl_low);
	assign sda = !(sda_oe || sda_pull || tb_sda_low);
	tsc_ctrl tsc_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .rx_byte_pulse(rx_byte_pulse));
	tsc_bus_model tsc_bus_model_i (.scl(scl), .sda(sda), .send_mode(send_mode),
		.send_byte(send_byte), .nack_sel(nack_sel), .grab_sda(grab_sda), .sda_pull(sda_pull),
		.got_byte(got_byte), .got_ack(got_ack));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [4:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// polls a register bit; the loop gives up after 3000 polls of a wait that never comes
	task automatic wait_bit(input logic [4:0] a, input int b, input logic v);
		rd[b] = !v;
		for (int n = 0; n < 3000 && rd[b] !== v; n++) apb(1'b0, a, 32'h0);
	endtask
	task automatic tx(input logic [7:0] b);
		apb(1'b1, OFS_TRN, {24'h0, b});
		wait_bit(OFS_STAT, ST_TX_IN_PROGRESS_FLAG, 1'b0);
		apb(1'b0, OFS_STAT, 32'h0);
	endtask
	// far side as bus master: each half step holds the pins for four clocks
	task automatic bb_half(input logic c, input logic d);
		tb_scl_low <= c;
		tb_sda_low <= d;
		repeat (4) @(posedge pclk);
	endtask
	task automatic bb_start;
		bb_half(1'b0, 1'b1);
		bb_half(1'b1, 1'b1);
	endtask
	task automatic bb_stop;
		bb_half(1'b1, 1'b1);
		bb_half(1'b0, 1'b1);
		bb_half(1'b0, 1'b0);
	endtask
	task automatic bb_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bb_half(1'b1, !b[i]);
			bb_half(1'b0, !b[i]);
			bb_half(1'b1, !b[i]);
		end
		bb_half(1'b1, 1'b0);
		bb_half(1'b0, 1'b0);
		ack = sda;
		bb_half(1'b1, 1'b0);
	endtask
	task automatic end_of_test;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) if (rx_byte_pulse === 1'b1) pulses++;
	initial begin
		repeat (60000) @(posedge pclk);
		num_errors++;
		end_of_test;
	end
	initial begin
		{presetn, psel, penable, pwrite, send_mode, nack_sel, grab_sda} = 7'h00;
		{paddr, pwdata, send_byte, rd} = '0;
		{tb_scl_low, tb_sda_low, ack_bit} = 3'h0;
		{num_errors, checks, pulses} = '0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (rows[i]) begin
			if (rows[i].wr) apb(1'b1, rows[i].a, rows[i].d);
			apb(1'b0, rows[i].a, 32'h0);
			chk(rd, rows[i].exp);
			chk(err_seen, rows[i].a == 5'h1C);
		end
		// start, then address 0x50 write to the far side and a transmit write while busy
		apb(1'b1, OFS_CON, 32'h8001);
		wait_bit(OFS_CON, CON_SEN, 1'b0);
		chk(rd[CON_SEN], 1'b0);
		apb(1'b0, OFS_STAT, 32'h0);
		chk(rd[4:3], 2'h1);
		apb(1'b1, OFS_TRN, 32'hA0);
		@(posedge pclk);
		apb(1'b0, OFS_STAT, 32'h0);
		chk({rd[ST_TX_IN_PROGRESS_FLAG], rd[ST_TBF]}, 2'h3);
		apb(1'b1, OFS_TRN, 32'h77);
		wait_bit(OFS_STAT, ST_TX_IN_PROGRESS_FLAG, 1'b0);
		chk({rd[15:14], rd[7], rd[5], rd[2], rd[0]}, 6'h08);
		chk(got_byte, 8'hA0);
		tx(8'h5A);
		chk({rd[15], rd[5], rd[1]}, 3'h0);
		chk(pulses, 0);
		nack_sel <= 1'b1;
		tx(8'h33);
		chk({rd[15], rd[6]}, 2'h2);
		nack_sel <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			send_byte <= 8'h3C + 8'(i);
			send_mode <= 1'b1;
			apb(1'b1, OFS_CON, 32'h8008);
			wait_bit(OFS_CON, CON_MASTER_RX_ENABLE, 1'b0);
			chk(rd[CON_MASTER_RX_ENABLE], 1'b0);
			apb(1'b0, OFS_RCV, 32'h0);
			chk(rd, 32'h3C + i);
			send_mode <= 1'b0;
			apb(1'b1, OFS_CON, i ? 32'h8010 : 32'h8030);
			wait_bit(OFS_CON, CON_ACK_SEQ_TRIGGER, 1'b0);
			chk(rd[CON_ACK_SEQ_TRIGGER], 1'b0);
			chk(got_ack, i == 0);
		end
		chk(pulses, 2);
		apb(1'b1, OFS_CON, 32'h8004);
		wait_bit(OFS_CON, CON_PEN, 1'b0);
		chk(rd[CON_PEN], 1'b0);
		apb(1'b0, OFS_STAT, 32'h0);
		chk(rd[4:3], 2'h2);
		// far side masters the bus; own address 0x51 with bit 0 excused accepts 0x50
		nack_sel <= 1'b1;
		bb_start;
		bb_byte(8'hA0, ack_bit);
		chk(ack_bit, 1'b0);
		bb_byte(8'h5A, ack_bit);
		chk(ack_bit, 1'b0);
		apb(1'b0, OFS_STAT, 32'h0);
		chk({rd[5], rd[3:1]}, 4'hD);
		chk(pulses, 3);
		// second byte lands on a full buffer
		bb_byte(8'h33, ack_bit);
		chk(ack_bit, 1'b1);
		apb(1'b0, OFS_STAT, 32'h0);
		chk({rd[6], rd[1]}, 2'h3);
		chk(pulses, 3);
		bb_stop;
		apb(1'b0, OFS_RCV, 32'h0);
		chk(rd, 32'h5A);
		apb(1'b1, OFS_STAT, 32'h0);
		apb(1'b0, OFS_STAT, 32'h0);
		chk({rd[7:6], rd[4], rd[1]}, 4'h2);
		// unmasked bit 1 differs: no acknowledge
		bb_start;
		bb_byte(8'hA4, ack_bit);
		chk(ack_bit, 1'b1);
		bb_stop;
		bb_start;
		bb_byte(8'hA1, ack_bit);
		chk(ack_bit, 1'b0);
		apb(1'b0, OFS_STAT, 32'h0);
		chk(rd[ST_RW], 1'b1);
		bb_stop;
		// general call with its enable, then stop clears the flag
		apb(1'b1, OFS_CON, 32'h8080);
		bb_start;
		bb_byte(8'h00, ack_bit);
		apb(1'b0, OFS_STAT, 32'h0);
		chk(rd[ST_GC], 1'b1);
		bb_stop;
		apb(1'b0, OFS_STAT, 32'h0);
		chk(rd[ST_GC], 1'b0);
		apb(1'b1, OFS_CON, 32'h8400);
		bb_start;
		bb_byte(8'hF0, ack_bit);
		bb_byte(8'h51, ack_bit);
		apb(1'b0, OFS_STAT, 32'h0);
		chk(rd[ST_TEN_BIT_MATCH_FLAG], 1'b1);
		bb_stop;
		apb(1'b0, OFS_STAT, 32'h0);
		chk(rd[ST_TEN_BIT_MATCH_FLAG], 1'b0);
		apb(1'b1, OFS_CON, 32'h8000);
		nack_sel <= 1'b0;
		// far side holds data low while the master sends ones
		apb(1'b1, OFS_CON, 32'h8001);
		wait_bit(OFS_CON, CON_SEN, 1'b0);
		apb(1'b1, OFS_TRN, 32'hFF);
		repeat (30) @(posedge pclk);
		grab_sda <= 1'b1;
		wait_bit(OFS_STAT, ST_BCL, 1'b1);
		grab_sda <= 1'b0;
		repeat (20) @(posedge pclk);
		apb(1'b0, OFS_STAT, 32'h0);
		chk(rd[ST_BCL], 1'b1);
		apb(1'b1, OFS_STAT, 32'h0);
		apb(1'b0, OFS_STAT, 32'h0);
		chk(rd[ST_BCL], 1'b0);
		end_of_test;
	end
endmodule // tb
bind tsc_ctrl tsc_chk tsc_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .rx_byte_pulse(rx_byte_pulse));
`default_nettype wire
